//--- hdl/serial_port_ctl.sv
// Serial port with its second control register behind an AXI4-Lite slave.
// Contract
// - Control register two is readable and writable at any time.
// - Bit 7 set: interrupt requested while transmit buffer empty flag is set.
// - Bit 6 set: interrupt requested while transmit done flag is set.
// - Bit 5 set: interrupt requested while receive buffer full flag is set.
// - Bit 4 set: interrupt requested while idle line flag is set.
// - Bit 3 turns transmitter on; transmit pin then acts as serial output.
// - Single-wire mode: direction bit decides if transmit pin sends or receives.
// - Clearing then setting tx_on during transmission queues one idle character.
// - After tx_on clears, pin stays driven until pending characters finish.
// - Bit 2 enables receiver; when off receive pin returns to port use.
// - With loopback the receive pin stays port I/O even with receiver on.
// - Bit 1 puts receiver in standby, ignoring traffic until wakeup.
// - Wakeup is idle line (method 0) or set data MSB (method 1).
// - Hardware clears standby itself when the wakeup condition is seen.
// - Writing bit 0 one then zero queues one break character.
// - While bit 0 stays one, breaks repeat; 10/11 or 13/14 bit times.
// - A second break may be queued before software clears bit 0.
// - Transmit empty flag set at reset and when buffer moves to shifter.
// - Transmit done flag set when buffer empty and nothing is being sent.
// - Loopback plus receiver source gives single-wire mode on transmit pin.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module serial_port_ctl import serial_port_pkg::*; #(
    parameter int BITC = BIT_CYCLES
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // AXI4-Lite write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Serial pins
    input wire logic i_rxd,
    input wire logic i_txd_in,
    output logic o_txd_out,
    output logic o_txd_oe,
    output logic o_txd_owned,
    output logic o_rxd_owned,
    // Interrupt request
    output logic o_irq
);
    tx_link_if lk();

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic have_aw_q, have_w_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [7:0] ctrl1_q, ctrl2_q;
    logic [8:0] tx_buf_q, rx_data_q, rx_sh_q;
    logic tbe_q, done_q, rx_full_q, idle_q, overrun_q;
    logic irq_q, txd_q, txd_oe_q, txd_owned_q, rxd_owned_q;
    rx_state_t rx_state_q;
    logic [15:0] rx_cnt_q;
    logic [3:0] rx_bits_q;
    logic rx_s_q, char_q, wake_q, armed_q;
    logic [8:0] char_data_q;
    logic [15:0] idle_cnt_q;
    logic wr_fire, wr_byte, rd_fire, rd_data, single_wire, tx_owned, rx_in, msb;
    logic [15:0] idle_lim;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == OFS_DATA) || (a == OFS_STATUS) || (a == OFS_CTRL1) || (a == OFS_CTRL2);
    endfunction

    assign wr_fire = have_aw_q & have_w_q & ~bvalid_q;
    assign wr_byte = wr_fire & wstrb_q[0];
    assign rd_fire = i_arvalid & arready_q;
    assign rd_data = rd_fire & (i_araddr == OFS_DATA);
    assign single_wire = ctrl1_q[C1_LOOPBACK] & ctrl1_q[C1_RX_SOURCE];
    assign tx_owned = ctrl2_q[C2_TX_ON] | lk.active | lk.pending;
    assign idle_lim = ctrl1_q[C1_NINE_BIT] ? 16'(IDLE_CYCLES_9 - 1) : 16'(IDLE_CYCLES_8 - 1);
    assign msb = ctrl1_q[C1_NINE_BIT] ? char_data_q[8] : char_data_q[7];

    always_comb begin
        if (!ctrl1_q[C1_LOOPBACK]) begin
            rx_in = i_rxd;
        end else if (ctrl1_q[C1_RX_SOURCE]) begin
            rx_in = i_txd_in;
        end else begin
            rx_in = lk.line;
        end
    end

    assign lk.tx_on = ctrl2_q[C2_TX_ON];
    assign lk.break_queue = ctrl2_q[C2_BREAK];
    assign lk.nine_bit = ctrl1_q[C1_NINE_BIT];
    assign lk.long_break = ctrl1_q[C1_LONG_BREAK];
    assign lk.buf_full = ~tbe_q;
    assign lk.buf_data = tx_buf_q;

    tx_engine #(.BITC(BITC)) u_tx (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .lk(lk)
    );

    // Write channel: address and data are taken in either order.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            aw_addr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (i_awvalid && awready_q) begin
                aw_addr_q <= i_awaddr;
                have_aw_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (i_wvalid && wready_q) begin
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
                have_w_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (wr_fire) begin
                have_aw_q <= 1'b0;
                have_w_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && i_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Read channel.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else begin
            if (rd_fire) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rresp_q <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
                unique case (i_araddr)
                    OFS_DATA: rdata_q <= {23'h0, rx_data_q};
                    OFS_STATUS: rdata_q <= {24'h0, tbe_q, done_q, rx_full_q, idle_q, overrun_q, 3'h0};
                    OFS_CTRL1: rdata_q <= {24'h0, ctrl1_q};
                    OFS_CTRL2: rdata_q <= {24'h0, ctrl2_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
            if (rvalid_q && i_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // Control registers; a software write to standby wins over a same-cycle wakeup.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ctrl1_q <= CTRL1_RST;
            ctrl2_q <= CTRL2_RST;
        end else begin
            if (wake_q) begin
                ctrl2_q[C2_STANDBY] <= 1'b0;
            end
            if (wr_byte && aw_addr_q == OFS_CTRL1) begin
                ctrl1_q <= wdata_q[7:0];
            end
            if (wr_byte && aw_addr_q == OFS_CTRL2) begin
                ctrl2_q <= wdata_q[7:0];
            end
        end
    end

    // Transmit buffer and its flags; the engine taking a value wins over a write.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            tx_buf_q <= 9'h000;
            tbe_q <= 1'b1;
            done_q <= 1'b1;
        end else begin
            if (wr_fire && aw_addr_q == OFS_DATA) begin
                if (wstrb_q[0]) begin
                    tx_buf_q[7:0] <= wdata_q[7:0];
                end
                if (wstrb_q[1]) begin
                    tx_buf_q[8] <= wdata_q[8];
                end
                tbe_q <= 1'b0;
            end
            if (lk.taken) begin
                tbe_q <= 1'b1;
            end
            done_q <= tbe_q & ~lk.active & ~lk.pending;
        end
    end

    // Receive shifter, sampling each bit at its middle.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rx_state_q <= RX_WAIT;
            rx_s_q <= 1'b1;
            rx_cnt_q <= 16'h0000;
            rx_bits_q <= 4'h0;
            rx_sh_q <= 9'h000;
            char_q <= 1'b0;
            char_data_q <= 9'h000;
        end else begin
            rx_s_q <= rx_in;
            char_q <= 1'b0;
            rx_cnt_q <= rx_cnt_q + 16'h0001;
            unique case (rx_state_q)
                RX_WAIT: begin
                    rx_cnt_q <= 16'h0000;
                    if (ctrl2_q[C2_RX_ON] && !rx_s_q) begin
                        rx_state_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt_q == 16'(BITC / 2)) begin
                        rx_cnt_q <= 16'h0000;
                        rx_bits_q <= 4'h0;
                        rx_state_q <= rx_s_q ? RX_WAIT : RX_BITS;
                    end
                end
                RX_BITS: begin
                    if (rx_cnt_q == 16'(BITC - 1)) begin
                        rx_cnt_q <= 16'h0000;
                        rx_sh_q <= {rx_s_q, rx_sh_q[8:1]};
                        rx_bits_q <= rx_bits_q + 4'h1;
                        if (rx_bits_q == (ctrl1_q[C1_NINE_BIT] ? 4'h8 : 4'h7)) begin
                            rx_state_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_q == 16'(BITC - 1)) begin
                        rx_state_q <= RX_WAIT;
                        char_q <= 1'b1;
                        char_data_q <= ctrl1_q[C1_NINE_BIT] ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
                    end
                end
            endcase
            if (!ctrl2_q[C2_RX_ON]) begin
                rx_state_q <= RX_WAIT;
            end
        end
    end

    // Receive flags, standby filtering and idle-line detection.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rx_data_q <= 9'h000;
            rx_full_q <= 1'b0;
            idle_q <= 1'b0;
            overrun_q <= 1'b0;
            wake_q <= 1'b0;
            armed_q <= 1'b0;
            idle_cnt_q <= 16'h0000;
        end else begin
            wake_q <= 1'b0;
            if (rd_data) begin
                rx_full_q <= 1'b0;
                idle_q <= 1'b0;
                overrun_q <= 1'b0;
            end
            if (rx_state_q != RX_WAIT || !rx_s_q) begin
                idle_cnt_q <= 16'h0000;
            end else if (idle_cnt_q != idle_lim) begin
                idle_cnt_q <= idle_cnt_q + 16'h0001;
            end else if (armed_q) begin
                armed_q <= 1'b0;
                if (ctrl2_q[C2_STANDBY]) begin
                    wake_q <= ~ctrl1_q[C1_WAKE_METHOD];
                end else begin
                    idle_q <= 1'b1;
                end
            end
            if (char_q) begin
                armed_q <= 1'b1;
                if (!ctrl2_q[C2_STANDBY] || (ctrl1_q[C1_WAKE_METHOD] && msb)) begin
                    wake_q <= ctrl2_q[C2_STANDBY];
                    if (rx_full_q && !rd_data) begin
                        overrun_q <= 1'b1;
                    end else begin
                        rx_data_q <= char_data_q;
                        rx_full_q <= 1'b1;
                    end
                end
            end
        end
    end

    // Registered pin control and interrupt request.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            irq_q <= 1'b0;
            txd_q <= 1'b1;
            txd_oe_q <= 1'b0;
            txd_owned_q <= 1'b0;
            rxd_owned_q <= 1'b0;
        end else begin
            irq_q <= (ctrl2_q[C2_TX_EMPTY_IE] & tbe_q)
                   | (ctrl2_q[C2_TX_DONE_IE] & done_q)
                   | (ctrl2_q[C2_RX_FULL_IE] & rx_full_q)
                   | (ctrl2_q[C2_IDLE_IE] & idle_q);
            txd_q <= lk.line;
            txd_owned_q <= tx_owned;
            txd_oe_q <= tx_owned & ~(single_wire & ~ctrl1_q[C1_WIRE_DIR]);
            rxd_owned_q <= ctrl2_q[C2_RX_ON] & ~ctrl1_q[C1_LOOPBACK];
        end
    end

    assign o_awready = awready_q;
    assign o_wready = wready_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign o_irq = irq_q;
    assign o_txd_out = txd_q;
    assign o_txd_oe = txd_oe_q;
    assign o_txd_owned = txd_owned_q;
    assign o_rxd_owned = rxd_owned_q;

    if (BITC < 4 || BITC > 65535) begin : g_bad_bitc
        $error("serial_port_ctl: bit time out of range");
    end
endmodule // serial_port_ctl

//--- hdl/serial_port_pkg.sv
// Constants, register map and state types for the serial port with its second control register.
package serial_port_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_HZ = 115_200;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
    localparam int CHAR_BITS_8 = 10;
    localparam int CHAR_BITS_9 = 11;
    localparam int IDLE_CYCLES_8 = CHAR_BITS_8 * BIT_CYCLES;
    localparam int IDLE_CYCLES_9 = CHAR_BITS_9 * BIT_CYCLES;
    localparam logic [3:0] DATA_LEN_8 = 4'hA;
    localparam logic [3:0] DATA_LEN_9 = 4'hB;
    localparam logic [3:0] BRK_LEN_8 = 4'hA;
    localparam logic [3:0] BRK_LEN_9 = 4'hB;
    localparam logic [3:0] LBRK_LEN_8 = 4'hD;
    localparam logic [3:0] LBRK_LEN_9 = 4'hE;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_DATA = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CTRL1 = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CTRL2 = 4'hC;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam int C2_TX_EMPTY_IE = 7;
    localparam int C2_TX_DONE_IE = 6;
    localparam int C2_RX_FULL_IE = 5;
    localparam int C2_IDLE_IE = 4;
    localparam int C2_TX_ON = 3;
    localparam int C2_RX_ON = 2;
    localparam int C2_STANDBY = 1;
    localparam int C2_BREAK = 0;
    localparam int C1_LOOPBACK = 7;
    localparam int C1_RX_SOURCE = 5;
    localparam int C1_NINE_BIT = 4;
    localparam int C1_WAKE_METHOD = 3;
    localparam int C1_WIRE_DIR = 1;
    localparam int C1_LONG_BREAK = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_DATA = 4'h2,
        TX_BREAK = 4'h4,
        TX_PREAMBLE = 4'h8
    } tx_state_t;
    typedef enum logic [3:0] {
        RX_WAIT = 4'h1,
        RX_START = 4'h2,
        RX_BITS = 4'h4,
        RX_STOP = 4'h8
    } rx_state_t;
endpackage

//--- hdl/tx_engine.sv
// Transmit engine: data, break and idle characters with pending queues.
`timescale 1ns/1ps
module tx_engine import serial_port_pkg::*; #(
    parameter int BITC = BIT_CYCLES
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Link to the front end
    tx_link_if.eng lk
);
    tx_state_t state_q;
    logic [15:0] cnt_q;
    logic [3:0] bits_q;
    logic [15:0] sh_q;
    logic line_q;
    logic taken_q;
    logic on_q;
    logic brk_q;
    logic idle_pend_q;
    logic brk_pend_q;
    logic tick;
    logic want_brk;

    assign tick = (cnt_q == 16'(BITC - 1));
    assign want_brk = brk_pend_q | (lk.tx_on & lk.break_queue);
    assign lk.taken = taken_q;
    assign lk.active = (state_q != TX_IDLE);
    assign lk.pending = idle_pend_q | brk_pend_q;
    assign lk.line = line_q;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            on_q <= 1'b0;
            brk_q <= 1'b0;
        end else begin
            on_q <= lk.tx_on;
            brk_q <= lk.break_queue;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_q <= TX_IDLE;
            cnt_q <= 16'h0000;
            bits_q <= 4'h0;
            sh_q <= 16'hFFFF;
            line_q <= 1'b1;
            taken_q <= 1'b0;
            idle_pend_q <= 1'b0;
            brk_pend_q <= 1'b0;
        end else begin
            taken_q <= 1'b0;
            unique case (state_q)
                TX_IDLE: begin
                    cnt_q <= 16'h0000;
                    if (want_brk) begin
                        state_q <= TX_BREAK;
                        brk_pend_q <= 1'b0;
                        line_q <= 1'b0;
                        sh_q <= 16'h0000;
                        if (lk.long_break) begin
                            bits_q <= lk.nine_bit ? LBRK_LEN_9 - 4'h1 : LBRK_LEN_8 - 4'h1;
                        end else begin
                            bits_q <= lk.nine_bit ? BRK_LEN_9 - 4'h1 : BRK_LEN_8 - 4'h1;
                        end
                    end else if (idle_pend_q) begin
                        state_q <= TX_PREAMBLE;
                        idle_pend_q <= 1'b0;
                        line_q <= 1'b1;
                        sh_q <= 16'hFFFF;
                        bits_q <= lk.nine_bit ? DATA_LEN_9 - 4'h1 : DATA_LEN_8 - 4'h1;
                    end else if (lk.tx_on && lk.buf_full) begin
                        state_q <= TX_DATA;
                        taken_q <= 1'b1;
                        line_q <= 1'b0;
                        if (lk.nine_bit) begin
                            sh_q <= {7'h7F, lk.buf_data[8:0]};
                            bits_q <= DATA_LEN_9 - 4'h1;
                        end else begin
                            sh_q <= {8'hFF, lk.buf_data[7:0]};
                            bits_q <= DATA_LEN_8 - 4'h1;
                        end
                    end else begin
                        line_q <= 1'b1;
                    end
                end
                TX_DATA, TX_BREAK, TX_PREAMBLE: begin
                    cnt_q <= tick ? 16'h0000 : cnt_q + 16'h0001;
                    if (tick) begin
                        if (bits_q == 4'h0) begin
                            state_q <= TX_IDLE;
                            // A last break ends on the tick itself, so it lasts whole bit times.
                            if (state_q == TX_BREAK && !want_brk) begin
                                line_q <= 1'b1;
                            end
                        end else begin
                            bits_q <= bits_q - 4'h1;
                            line_q <= (state_q == TX_BREAK) ? 1'b0 : sh_q[0];
                            sh_q <= {1'b1, sh_q[15:1]};
                        end
                    end
                end
            endcase
            if (lk.tx_on && !on_q) begin
                idle_pend_q <= 1'b1;
            end
            // A break that starts at this very edge has already used up the request's rising edge.
            if (lk.break_queue && !brk_q && !(state_q == TX_IDLE && lk.tx_on)) begin
                brk_pend_q <= 1'b1;
            end
        end
    end

    if (BITC < 4 || BITC > 65535) begin : g_bad_bitc
        $error("tx_engine: bit time out of range");
    end
endmodule // tx_engine

//--- hdl/tx_link_if.sv
// Signals between the register front end and the transmit engine.
`timescale 1ns/1ps
interface tx_link_if;
    logic tx_on;
    logic break_queue;
    logic nine_bit;
    logic long_break;
    logic buf_full;
    logic [8:0] buf_data;
    logic taken;
    logic active;
    logic pending;
    logic line;
    modport ctl(output tx_on, break_queue, nine_bit, long_break, buf_full, buf_data,
                input taken, active, pending, line);
    modport eng(input tx_on, break_queue, nine_bit, long_break, buf_full, buf_data,
                output taken, active, pending, line);
endinterface

//--- verif/remote_node.sv
// Remote serial node: sends frames and samples the transmit line.
`timescale 1ns/1ps
module remote_node #(parameter int BITC = 8) (
    input wire logic i_clk,
    input wire logic i_txd_out,
    input wire logic i_txd_oe,
    output logic o_rxd,
    output logic o_line
);
    int low_q = 0;
    int last_low = 0;
    // The transmit line is pulled up while the device does not drive it.
    assign o_line = i_txd_oe ? i_txd_out : 1'b1;
    initial o_rxd = 1'b1;
    always @(posedge i_clk) begin
        low_q <= o_line ? 0 : low_q + 1;
        if (o_line && low_q != 0) last_low <= low_q;
    end
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_rxd <= f[i];
            repeat (BITC) @(posedge i_clk);
        end
    endtask
    task automatic grab(output logic [7:0] b);
        wait (o_line === 1'b1);
        wait (o_line === 1'b0);
        repeat (BITC / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BITC) @(posedge i_clk);
            b[i] = o_line;
        end
    endtask
endmodule // remote_node

//--- verif/serial_port_control_two_tb.sv
// Bench for the serial port second control register.
`timescale 1ns/1ps
module serial_port_control_two_tb;
    import serial_port_pkg::*;
    localparam int BT = 8;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, i_rxd, i_txd_in, o_awready, o_wready, o_bvalid, o_arready;
    logic o_rvalid, o_txd_out, o_txd_oe, o_txd_owned, o_rxd_owned, o_irq;
    logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [1:0] o_bresp, o_rresp;
    logic [7:0] b;
    int num_errors = 0, check_count = 0, cyc = 0;
    always #20 i_core_clk = ~i_core_clk;
    serial_port_ctl #(.BITC(BT)) serial_port_ctl_i (.i_core_clk, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr,
        .i_wvalid, .o_wready, .i_wdata, .i_wstrb(4'hF), .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
        .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_rxd, .i_txd_in, .o_txd_out, .o_txd_oe,
        .o_txd_owned, .o_rxd_owned, .o_irq);
    remote_node #(.BITC(BT)) remote_node_i (.i_clk(i_core_clk), .i_txd_out(o_txd_out), .i_txd_oe(o_txd_oe),
        .o_rxd(i_rxd), .o_line(i_txd_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, d, 3'h7};
        do begin
            @(posedge i_core_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (!o_bvalid);
        chk(o_bresp, er);
        i_bready <= 1'b0;
        pause(1);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        {i_araddr, i_arvalid, i_rready} <= {a, 2'h3};
        do begin
            @(posedge i_core_clk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid);
        chk(o_rdata, e);
        chk(o_rresp, er);
        i_rready <= 1'b0;
        pause(1);
    endtask
    task automatic t_regs();
        logic [7:0] en [5] = '{8'hF0, 8'h80, 8'h40, 8'h20, 8'h10};
        logic ie [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        chk(o_irq, 0);
        rd(OFS_CTRL2, 0);
        rd(OFS_STATUS, 32'hC0);
        for (int k = 0; k < 5; k++) begin
            wr(OFS_CTRL2, en[k]);
            rd(OFS_CTRL2, en[k]);
            chk(o_irq, ie[k]);
        end
        wr(4'h2, 32'hFF, RESP_SLVERR);
        rd(4'h2, 0, RESP_SLVERR);
        $display("register test done");
    endtask
    task automatic t_tx();
        wr(OFS_CTRL2, 8'h08);
        chk(o_txd_owned, 1);
        chk(o_txd_oe, 1);
        wr(OFS_DATA, 32'h55);
        remote_node_i.grab(b);
        chk(b, 8'h55);
        wr(OFS_DATA, 32'hA3);
        pause(2 * BT);
        wr(OFS_CTRL2, 8'h00);
        chk(o_txd_owned, 1);
        pause(12 * BT);
        chk(o_txd_owned, 0);
        rd(OFS_STATUS, 32'hC0);
        $display("transmit test done");
    endtask
    task automatic t_break();
        logic [7:0] c1 [4] = '{8'h00, 8'h10, 8'h01, 8'h11};
        int nb [4] = '{10, 11, 13, 14};
        for (int k = 0; k < 4; k++) begin
            wr(OFS_CTRL1, c1[k]);
            wr(OFS_CTRL2, 8'h09);
            wr(OFS_CTRL2, 8'h08);
            pause(30 * BT);
            chk(remote_node_i.last_low, nb[k] * BT);
        end
        $display("break test done");
    endtask
    task automatic t_rx();
        wr(OFS_CTRL1, 8'h08);
        wr(OFS_CTRL2, 8'h24);
        chk(o_rxd_owned, 1);
        remote_node_i.send(8'h3C);
        pause(BT);
        chk(o_irq, 1);
        rd(OFS_DATA, 32'h3C);
        chk(o_irq, 0);
        wr(OFS_CTRL2, 8'h26);
        remote_node_i.send(8'h11);
        pause(BT);
        chk(o_irq, 0);
        remote_node_i.send(8'h91);
        pause(BT);
        chk(o_irq, 1);
        rd(OFS_CTRL2, 32'h24);
        rd(OFS_DATA, 32'h91);
        wr(OFS_CTRL2, 8'h0C);
        wr(OFS_CTRL1, 8'hA0);
        chk(o_rxd_owned, 0);
        chk(o_txd_oe, 0);
        wr(OFS_CTRL1, 8'hA2);
        chk(o_txd_oe, 1);
        $display("receive test done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        pause(6);
        i_rst_n <= 1'b1;
        pause(1);
        t_regs();
        t_tx();
        t_break();
        t_rx();
        give_verdict();
    end
endmodule // serial_port_control_two_tb

//--- verif/serial_port_ctl_props.sv
// Assertions on the serial port top-level ports.
`timescale 1ns/1ps
module serial_port_ctl_props (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic o_txd_out,
    input wire logic o_txd_oe,
    input wire logic o_txd_owned,
    input wire logic o_rxd_owned,
    input wire logic o_irq
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence wr_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence rd_taken;
        i_arvalid && o_arready;
    endsequence
    reset_quiet_a: assert property (disable iff (1'b0) !i_rst_n |=> !o_irq && !o_txd_owned && o_txd_out)
        else $error("outputs busy after reset");
    write_answer_a: assert property (wr_taken |-> ##[1:2] o_bvalid)
        else $error("no write response");
    read_answer_a: assert property (rd_taken |-> ##[1:2] o_rvalid)
        else $error("no read response");
    write_busy_a: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write ready during response");
    read_busy_a: assert property (o_rvalid |-> !o_arready)
        else $error("read ready during response");
    drive_owned_a: assert property (o_txd_oe |-> o_txd_owned)
        else $error("pin driven while not owned");
    release_high_a: assert property (!o_txd_owned |-> o_txd_out)
        else $error("released line not idle");
    rx_owner_a: assert property ($changed(o_rxd_owned) |-> o_bvalid || $past(o_bvalid) || $past(o_bvalid, 2))
        else $error("receive pin owner changed without write");
endmodule // serial_port_ctl_props

bind serial_port_ctl serial_port_ctl_props serial_port_ctl_props_i (.i_core_clk, .i_rst_n, .i_awvalid,
    .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_arvalid, .o_arready, .o_rvalid, .o_txd_out, .o_txd_oe,
    .o_txd_owned, .o_rxd_owned, .o_irq);
